// ==== include/hbc_pkg.sv ====
// Purpose: shared constants and types for the dual h-bridge chopper control
// Assumes: 25 MHz aclk, chopping oscillator sampled as a plain input
// Notes:   register map reached over AXI4-Lite, 32-bit data

package hbc_pkg;

   // clock and blanking timing
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned ANALOG_BLANK_NS = 400;
   localparam int unsigned ANALOG_BLANK_CYC =
      (ANALOG_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;   // least time, round up
   localparam logic [3:0]  ABLANK_LOAD   = 4'(ANALOG_BLANK_CYC);
   localparam logic [2:0]  DBLANK_SHORT  = 3'h4;               // oscillator clocks
   localparam logic [2:0]  DBLANK_LONG   = 3'h6;

   // chopping period: 16 oscillator clocks, fast decay from the 11th
   localparam logic [3:0]  FAST_EDGE     = 4'ha;
   localparam logic [3:0]  LAST_EDGE     = 4'hf;

   // register offsets and layout
   localparam logic [31:0] CTRL_OFS      = 32'h0000_0000;
   localparam logic [31:0] STAT_OFS      = 32'h0000_0004;
   localparam logic [1:0]  CTRL_RST      = 2'h3;
   localparam int unsigned CTRL_CC_A     = 0;
   localparam int unsigned CTRL_CC_B     = 1;
   localparam int unsigned STAT_STBY     = 0;
   localparam int unsigned STAT_MERGE    = 1;
   localparam int unsigned STAT_PHA_LSB  = 2;
   localparam int unsigned STAT_PHB_LSB  = 4;
   localparam int unsigned STAT_BLK_A    = 6;
   localparam int unsigned STAT_BLK_B    = 7;
   localparam int unsigned STAT_CNT_LSB  = 8;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_DECERR   = 2'h3;

   typedef enum logic [1:0] {
      HBC_CHARGE = 2'b00,
      HBC_SLOW   = 2'b01,
      HBC_FAST   = 2'b10
   } hbc_phase_t;

   typedef enum logic [1:0] {
      HBC_OFF   = 2'b00,
      HBC_BRAKE = 2'b01,
      HBC_CCW   = 2'b10,
      HBC_CW    = 2'b11
   } hbc_drive_t;

   typedef enum logic [1:0] {
      HBC_SEL_CTRL = 2'b00,
      HBC_SEL_STAT = 2'b01,
      HBC_SEL_NONE = 2'b10
   } hbc_sel_t;

   // switch gates of one bridge
   typedef struct packed {
      logic u1;
      logic u2;
      logic l1;
      logic l2;
   } hbc_sw_t;

   // chopper state of one bridge
   typedef struct packed {
      hbc_phase_t  phase;
      logic [3:0]  cnt;
      logic [2:0]  dblank;
      logic [3:0]  ablank;
   } hbc_chop_t;

   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } hbc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } hbc_axi_rsp_t;

   typedef struct packed {
      hbc_axi_rsp_t rsp;
      logic         aw_got;
      logic [31:0]  aw_addr;
      logic         w_got;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic [1:0]   ctrl;
      logic [3:0]   dir_prev;
      logic         osc_prev;
      logic         standby;
      hbc_chop_t    chop_a;
      hbc_chop_t    chop_b;
      hbc_sw_t      sw_a;
      hbc_sw_t      sw_b;
   } hbc_state_t;

endpackage : hbc_pkg

// ==== rtl/hbc_chopper_ctl.sv ====
// Purpose: dual h-bridge decode, standby and constant-current chopping
// Assumes: all pins synchronous to aclk; oscillator sampled on aclk
// Notes:   switch gates are registered; AXI4-Lite holds ctrl and status
//
// The AXI4-Lite register port and the address map are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module hbc_chopper_ctl (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire hbc_pkg::hbc_axi_req_t axi_req,
   output var  hbc_pkg::hbc_axi_rsp_t axi_rsp,
   input  wire logic                  a_dir_ctl1,
   input  wire logic                  a_dir_ctl2,
   input  wire logic                  a_chop_gate,
   input  wire logic                  b_dir_ctl1,
   input  wire logic                  b_dir_ctl2,
   input  wire logic                  b_chop_gate,
   input  wire logic                  blank_len_sel,
   input  wire logic                  bridge_merge_sel,
   input  wire logic                  chop_osc_clk,
   input  wire logic                  a_current_limit_trip,
   input  wire logic                  b_current_limit_trip,
   output var  hbc_pkg::hbc_sw_t      a_sw,
   output var  hbc_pkg::hbc_sw_t      b_sw,
   output var  logic                  standby
);

   hbc_pkg::hbc_state_t s_q;
   hbc_pkg::hbc_state_t s_d;
   logic                osc_edge;
   logic [3:0]          dir_now;
   logic [2:0]          blank_len;

   // input decode of one bridge
   function automatic hbc_pkg::hbc_drive_t decode(input logic d1, input logic d2,
                                                  input logic gate);
      hbc_pkg::hbc_drive_t r;
      r = hbc_pkg::HBC_OFF;
      if (!gate) begin
         r = (d1 || d2) ? hbc_pkg::HBC_BRAKE : hbc_pkg::HBC_OFF;
      end else begin
         case ({d1, d2})
            2'b00:   r = hbc_pkg::HBC_OFF;
            2'b01:   r = hbc_pkg::HBC_CCW;
            2'b10:   r = hbc_pkg::HBC_CW;
            2'b11:   r = hbc_pkg::HBC_BRAKE;
            default: r = hbc_pkg::HBC_OFF;
         endcase
      end
      return r;
   endfunction : decode

   // switch gates from drive state and chopping phase
   function automatic hbc_pkg::hbc_sw_t gates(input hbc_pkg::hbc_drive_t drv,
                                              input hbc_pkg::hbc_phase_t ph);
      hbc_pkg::hbc_sw_t g;
      g = '0;
      case (drv)
         hbc_pkg::HBC_BRAKE: g = '{u1: 1'b0, u2: 1'b0, l1: 1'b1, l2: 1'b1};
         hbc_pkg::HBC_CW: begin
            case (ph)
               hbc_pkg::HBC_SLOW: g = '{u1: 1'b0, u2: 1'b0, l1: 1'b1, l2: 1'b1};
               hbc_pkg::HBC_FAST: g = '{u1: 1'b0, u2: 1'b1, l1: 1'b1, l2: 1'b0};
               default:           g = '{u1: 1'b1, u2: 1'b0, l1: 1'b0, l2: 1'b1};
            endcase
         end
         hbc_pkg::HBC_CCW: begin
            case (ph)
               hbc_pkg::HBC_SLOW: g = '{u1: 1'b0, u2: 1'b0, l1: 1'b1, l2: 1'b1};
               hbc_pkg::HBC_FAST: g = '{u1: 1'b1, u2: 1'b0, l1: 1'b0, l2: 1'b1};
               default:           g = '{u1: 1'b0, u2: 1'b1, l1: 1'b1, l2: 1'b0};
            endcase
         end
         default: g = '0;                                            // off, hi-z
      endcase
      return g;
   endfunction : gates

   // one aclk step of a bridge chopper
   function automatic hbc_pkg::hbc_chop_t chop_step(input hbc_pkg::hbc_chop_t cur,
                                                    input logic driving,
                                                    input logic cc_en,
                                                    input logic edge_i,
                                                    input logic trip,
                                                    input logic restart,
                                                    input logic [2:0] len);
      hbc_pkg::hbc_chop_t n;
      logic               wrap;
      n    = cur;
      wrap = edge_i && (cur.cnt == hbc_pkg::LAST_EDGE);
      if (!driving) begin
         // idle: preload so blanking covers the first charge
         n.phase  = hbc_pkg::HBC_CHARGE;
         n.cnt    = 4'h0;
         n.dblank = len;
         n.ablank = hbc_pkg::ABLANK_LOAD;
      end else begin
         if (cur.ablank != 4'h0) begin
            n.ablank = cur.ablank - 4'h1;
         end
         if (edge_i && cur.dblank != 3'h0) begin
            n.dblank = cur.dblank - 3'h1;
         end
         if (wrap) begin
            n.cnt    = 4'h0;
            n.phase  = hbc_pkg::HBC_CHARGE;
            n.dblank = len;
            n.ablank = hbc_pkg::ABLANK_LOAD;
         end else if (edge_i) begin
            n.cnt = cur.cnt + 4'h1;
            if (n.cnt == hbc_pkg::FAST_EDGE) begin
               n.phase = hbc_pkg::HBC_FAST;
            end
         end
         // trip honoured only in charge with both blankings done
         if (!wrap && n.phase == hbc_pkg::HBC_CHARGE && trip &&
             cur.dblank == 3'h0 && cur.ablank == 4'h0) begin
            n.phase = hbc_pkg::HBC_SLOW;
         end
         if (restart) begin
            n.dblank = len;
            n.ablank = hbc_pkg::ABLANK_LOAD;
         end
         if (!cc_en) begin
            n.phase = hbc_pkg::HBC_CHARGE;                           // direct pwm
         end
      end
      return n;
   endfunction : chop_step

   // register decode, shared by the read and write paths
   function automatic hbc_pkg::hbc_sel_t reg_sel(input logic [31:0] addr);
      hbc_pkg::hbc_sel_t r;
      r = hbc_pkg::HBC_SEL_NONE;
      if ({addr[31:2], 2'b00} == hbc_pkg::CTRL_OFS) begin
         r = hbc_pkg::HBC_SEL_CTRL;
      end else if ({addr[31:2], 2'b00} == hbc_pkg::STAT_OFS) begin
         r = hbc_pkg::HBC_SEL_STAT;
      end
      return r;
   endfunction : reg_sel

   // oscillator edge, direction snapshot, blanking length
   assign osc_edge  = chop_osc_clk && !s_q.osc_prev;
   assign dir_now   = {a_dir_ctl1, a_dir_ctl2, b_dir_ctl1, b_dir_ctl2};
   assign blank_len = blank_len_sel ? hbc_pkg::DBLANK_LONG
                                    : hbc_pkg::DBLANK_SHORT;

   // next state: bus slave and both bridges
   always_comb begin
      hbc_pkg::hbc_drive_t drv_a;
      hbc_pkg::hbc_drive_t drv_b;
      hbc_pkg::hbc_sel_t   sel;
      logic                dir_chg;
      logic [31:0]         rd;
      drv_a   = hbc_pkg::HBC_OFF;
      drv_b   = hbc_pkg::HBC_OFF;
      sel     = hbc_pkg::HBC_SEL_NONE;
      dir_chg = 1'b0;
      rd      = 32'h0000_0000;
      s_d     = s_q;

      // write address and data are taken independently
      if (axi_req.awvalid && s_q.rsp.awready) begin
         s_d.aw_got  = 1'b1;
         s_d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && s_q.rsp.wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = axi_req.wdata;
         s_d.wstrb = axi_req.wstrb;
      end
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      if (s_d.aw_got && s_d.w_got && !s_d.rsp.bvalid) begin
         sel            = reg_sel(s_d.aw_addr);
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp  = (sel == hbc_pkg::HBC_SEL_NONE) ? hbc_pkg::RESP_DECERR
                                                          : hbc_pkg::RESP_OKAY;
         if (sel == hbc_pkg::HBC_SEL_CTRL && s_d.wstrb[0]) begin
            s_d.ctrl = s_d.wdata[1:0];
         end
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
      end
      s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
      s_d.rsp.wready  = !s_d.w_got && !s_d.rsp.bvalid;

      // read channel: answer one cycle after the address
      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && s_q.rsp.arready) begin
         sel = reg_sel(axi_req.araddr);
         case (sel)
            hbc_pkg::HBC_SEL_CTRL: rd[1:0] = s_q.ctrl;
            hbc_pkg::HBC_SEL_STAT: begin
               rd[hbc_pkg::STAT_STBY]  = s_q.standby;
               rd[hbc_pkg::STAT_MERGE] = bridge_merge_sel;
               rd[hbc_pkg::STAT_PHA_LSB +: 2] = s_q.chop_a.phase;
               rd[hbc_pkg::STAT_PHB_LSB +: 2] = s_q.chop_b.phase;
               rd[hbc_pkg::STAT_BLK_A] = (s_q.chop_a.dblank != 3'h0);
               rd[hbc_pkg::STAT_BLK_B] = (s_q.chop_b.dblank != 3'h0);
               rd[hbc_pkg::STAT_CNT_LSB +: 4] = s_q.chop_a.cnt;
            end
            default: rd = 32'h0000_0000;
         endcase
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata  = rd;
         s_d.rsp.rresp  = (sel == hbc_pkg::HBC_SEL_NONE) ? hbc_pkg::RESP_DECERR
                                                          : hbc_pkg::RESP_OKAY;
      end
      s_d.rsp.arready = !s_d.rsp.rvalid;

      // standby and input decode
      s_d.standby  = !(a_dir_ctl1 || a_dir_ctl2 || a_chop_gate ||
                       b_dir_ctl1 || b_dir_ctl2 || b_chop_gate);
      dir_chg      = (dir_now != s_q.dir_prev);
      s_d.dir_prev = dir_now;
      s_d.osc_prev = chop_osc_clk;
      drv_a        = decode(a_dir_ctl1, a_dir_ctl2, a_chop_gate);
      drv_b        = decode(b_dir_ctl1, b_dir_ctl2, b_chop_gate);

      // chopper of bridge A; in merged mode the sense inputs are tied
      s_d.chop_a = chop_step(s_q.chop_a,
                             drv_a == hbc_pkg::HBC_CW || drv_a == hbc_pkg::HBC_CCW,
                             s_q.ctrl[hbc_pkg::CTRL_CC_A], osc_edge,
                             a_current_limit_trip ||
                                (bridge_merge_sel && b_current_limit_trip),
                             dir_chg, blank_len);
      s_d.sw_a   = gates(drv_a, s_d.chop_a.phase);

      if (bridge_merge_sel) begin
         s_d.chop_b = s_d.chop_a;
         s_d.sw_b   = s_d.sw_a;
      end else begin
         s_d.chop_b = chop_step(s_q.chop_b,
                                drv_b == hbc_pkg::HBC_CW || drv_b == hbc_pkg::HBC_CCW,
                                s_q.ctrl[hbc_pkg::CTRL_CC_B], osc_edge,
                                b_current_limit_trip, dir_chg, blank_len);
         s_d.sw_b   = gates(drv_b, s_d.chop_b.phase);
      end
      if (s_d.standby) begin
         s_d.sw_a = '0;
         s_d.sw_b = '0;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q      <= '0;
         s_q.ctrl <= hbc_pkg::CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign axi_rsp = s_q.rsp;
   assign a_sw    = s_q.sw_a;
   assign b_sw    = s_q.sw_b;
   assign standby = s_q.standby;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_standby_off: assert property (
      s_q.standby |-> (s_q.sw_a == '0 && s_q.sw_b == '0))
      else $error("outputs driven in standby");

   a_standby_exit: assert property (
      (a_dir_ctl1 || a_dir_ctl2 || a_chop_gate ||
       b_dir_ctl1 || b_dir_ctl2 || b_chop_gate) |=> !s_q.standby)
      else $error("standby held with an input high");

   a_brake_a: assert property (
      (!a_chop_gate && (a_dir_ctl1 || a_dir_ctl2)) |=>
         s_q.sw_a == hbc_pkg::hbc_sw_t'{u1: 1'b0, u2: 1'b0, l1: 1'b1, l2: 1'b1})
      else $error("bridge a not braking with gate low");

   a_brake_both: assert property (
      (b_chop_gate && b_dir_ctl1 && b_dir_ctl2 && !bridge_merge_sel) |=>
         s_q.sw_b == hbc_pkg::hbc_sw_t'{u1: 1'b0, u2: 1'b0, l1: 1'b1, l2: 1'b1})
      else $error("bridge b not braking with both dirs high");

   a_blank_load: assert property (
      (a_chop_gate && a_dir_ctl1 && !a_dir_ctl2 && dir_now != s_q.dir_prev) |=>
         s_q.chop_a.dblank == ($past(blank_len_sel) ? 3'h6 : 3'h4))
      else $error("digital blanking not reloaded to its length");

   a_blank_mask: assert property (
      (s_q.chop_a.phase == hbc_pkg::HBC_CHARGE &&
       (s_q.chop_a.dblank != 3'h0 || s_q.chop_a.ablank != 4'h0)) |=>
         s_q.chop_a.phase != hbc_pkg::HBC_SLOW)
      else $error("slow decay entered during blanking");

   a_fast_window: assert property (
      s_q.ctrl[0] |-> ((s_q.chop_a.cnt >= 4'ha) == (s_q.chop_a.phase == hbc_pkg::HBC_FAST)))
      else $error("fast decay outside the last six clocks");

   a_period_wrap: assert property (
      (s_q.chop_a.cnt == 4'hf && osc_edge) |=>
         (s_q.chop_a.cnt == 4'h0 && s_q.chop_a.phase == hbc_pkg::HBC_CHARGE))
      else $error("period did not restart after sixteen clocks");

   a_merge_copy: assert property (
      (bridge_merge_sel && $past(bridge_merge_sel)) |-> s_q.sw_b == s_q.sw_a)
      else $error("bridge b not following bridge a when merged");

   a_no_shoot: assert property (
      !((s_q.sw_a.u1 && s_q.sw_a.l1) || (s_q.sw_a.u2 && s_q.sw_a.l2)))
      else $error("shoot-through on bridge a");

endmodule : hbc_chopper_ctl

`default_nettype wire

// ==== verification/hbc_host_model.sv ====
// Purpose: host side model driving the motor inputs and the chopping oscillator
// Assumes: oscillator runs at one eighth of aclk while chopping is wanted
// Notes:   merge select is only ever changed by the bench while reset is held
`timescale 1ns/1ps
`default_nettype none

module hbc_host_model (
   input  wire logic       aclk,
   input  wire logic [5:0] drv,
   input  wire logic       merge,
   input  wire logic       b_free,
   input  wire logic       run,
   output wire logic [5:0] pins,
   output wire logic       merge_pin,
   output wire logic       osc
);
   logic [2:0] osc_cnt_q;

   // bridge b held low in merged mode unless a scenario frees it
   assign pins      = {drv[5:3], (merge && !b_free) ? 3'h0 : drv[2:0]};
   assign merge_pin = merge;

   // oscillator divider, stopped and low outside chopping
   always_ff @(posedge aclk) begin
      if (!run) begin
         osc_cnt_q <= 3'h0;
      end else begin
         osc_cnt_q <= osc_cnt_q + 3'h1;
      end
   end
   assign osc = osc_cnt_q[2];
endmodule : hbc_host_model

`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the dual h-bridge chopper control
// Assumes: 25 MHz aclk, synchronous active-low reset
// Notes:   expected switch sets follow from decode and chopping timing
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic                  aclk, aresetn, trip_a, trip_b, lsel, merge, b_free, run;
   logic [5:0]            drv, pins;
   logic                  osc, merge_pin, standby;
   hbc_pkg::hbc_axi_req_t req;
   hbc_pkg::hbc_axi_rsp_t rsp;
   hbc_pkg::hbc_sw_t      a_sw, b_sw;
   int                    error_cnt, check_count;
   logic [31:0]           rdat;
   logic [1:0]            rcode;

   hbc_host_model host_u (.aclk(aclk), .drv(drv), .merge(merge), .b_free(b_free), .run(run),
      .pins(pins), .merge_pin(merge_pin), .osc(osc));
   hbc_chopper_ctl dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .a_dir_ctl1(pins[5]), .a_dir_ctl2(pins[4]), .a_chop_gate(pins[3]),
      .b_dir_ctl1(pins[2]), .b_dir_ctl2(pins[1]), .b_chop_gate(pins[0]),
      .blank_len_sel(lsel), .bridge_merge_sel(merge_pin), .chop_osc_clk(osc),
      .a_current_limit_trip(trip_a), .b_current_limit_trip(trip_b),
      .a_sw(a_sw), .b_sw(b_sw), .standby(standby));

   // 40 ns clock
   initial aclk = 1'b0;
   always #20 aclk = ~aclk;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   // write: address and data together, each released when taken
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d, wstrb:4'hf, bready:1'b1,
               default:'0};
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (req.awvalid && !rsp.awready || req.wvalid && !rsp.wready);
      do @(posedge aclk); while (!rsp.bvalid);
      r = rsp.bresp;
      req.bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
      do @(posedge aclk); while (!rsp.arready);
      req.arvalid <= 1'b0;
      do @(posedge aclk); while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask : axi_rd

   // switch set of one bridge for {dir1, dir2, gate} in charge
   function automatic logic [3:0] dec(input logic [2:0] c);
      case (c)
         3'h0, 3'h1: dec = 4'h0;
         3'h3:       dec = 4'h6;
         3'h5:       dec = 4'h9;
         default:    dec = 4'h3;
      endcase
   endfunction : dec

   task automatic drive(input logic [5:0] v);
      @(posedge aclk);
      drv <= v;
      repeat (2) @(posedge aclk);
      #1;
   endtask : drive

   // reset values, unmapped place, read-only word, write back
   task automatic t_regs;
      axi_rd(hbc_pkg::CTRL_OFS, rdat, rcode);
      chk("ctrl reset", 32'(hbc_pkg::CTRL_RST), rdat);
      axi_rd(hbc_pkg::STAT_OFS, rdat, rcode);
      chk("status idle", 32'h1, rdat & 32'h3);
      axi_rd(32'h0000_0010, rdat, rcode);
      chk("unmapped rresp", 32'(hbc_pkg::RESP_DECERR), 32'(rcode));
      chk("unmapped rdata", 32'h0, rdat);
      axi_wr(32'h0000_0010, 32'h0, rcode);
      chk("unmapped bresp", 32'(hbc_pkg::RESP_DECERR), 32'(rcode));
      axi_wr(hbc_pkg::STAT_OFS, 32'hffff_ffff, rcode);
      chk("status bresp", 32'(hbc_pkg::RESP_OKAY), 32'(rcode));
      axi_wr(hbc_pkg::CTRL_OFS, 32'h0, rcode);
      axi_rd(hbc_pkg::CTRL_OFS, rdat, rcode);
      chk("ctrl written", 32'h0, rdat);
   endtask : t_regs

   // standby entry and exit, full decode table on both bridges
   task automatic t_decode;
      drive(6'h00);
      chk("standby", 32'h1, 32'(standby));
      chk("a hi-z", 32'h0, 32'(a_sw));
      for (int i = 0; i < 6; i++) begin
         drive(6'h01 << i);
         chk("standby", 32'h0, 32'(standby));
      end
      for (int c = 0; c < 8; c++) begin
         drive({3'(c), 3'(7 - c)});
         chk("a decode", 32'(dec(3'(c))), 32'(a_sw));
         chk("b decode", 32'(dec(3'(7 - c))), 32'(b_sw));
      end
   endtask : t_decode

   // chopping run on both bridges, b reversed with the other trip, sampled between osc edges
   task automatic t_chop(input logic [2:0] c, input logic tr, input logic ls);
      logic [3:0] ch, chb, ex, exb;
      int         k, m;
      int         pts[8] = '{3, 5, 7, 9, 10, 15, 16, 19};
      ch = dec(c);
      chb = dec(c ^ 3'h6);
      k = 0;
      @(posedge aclk);
      drv <= {c, c ^ 3'h6};
      trip_a <= tr;
      trip_b <= !tr;
      lsel <= ls;
      run <= 1'b1;
      foreach (pts[i]) begin
         while (k < pts[i]) begin
            @(posedge osc);
            k++;
         end
         repeat (4) @(posedge aclk);
         #1;
         m = k % 16;
         ex = (m >= 10) ? ~ch : ((tr || merge) && m > (ls ? 6 : 4)) ? 4'h3 : ch;
         exb = (m >= 10) ? ~chb : (!tr && m > (ls ? 6 : 4)) ? 4'h3 : chb;
         chk("a chop", 32'(ex), 32'(a_sw));
         chk("b chop", merge ? 32'(ex) : 32'(exb), 32'(b_sw));
      end
      @(posedge aclk);
      drv <= 6'h00;
      trip_a <= 1'b0;
      trip_b <= 1'b0;
      run <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : t_chop

   // merged bridge: change select under reset, bridge b inputs ignored
   task automatic t_merge;
      @(posedge aclk);
      aresetn <= 1'b0;
      merge <= 1'b1;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_chop(3'h5, 1'b0, 1'b1);
      @(posedge aclk);
      b_free <= 1'b1;
      drive(6'h1d);
      chk("merged a", 32'h6, 32'(a_sw));
      chk("merged b", 32'h6, 32'(b_sw));
      axi_rd(hbc_pkg::STAT_OFS, rdat, rcode);
      chk("status merged", 32'hc2, rdat & 32'hfff);
   endtask : t_merge

   // main sequence
   initial begin
      aresetn = 1'b0;
      req = '0;
      drv = 6'h00;
      trip_a = 1'b0;
      trip_b = 1'b0;
      lsel = 1'b0;
      merge = 1'b0;
      b_free = 1'b0;
      run = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_decode();
      axi_wr(hbc_pkg::CTRL_OFS, 32'h3, rcode);
      t_chop(3'h5, 1'b1, 1'b0);
      t_chop(3'h3, 1'b1, 1'b1);
      t_chop(3'h5, 1'b0, 1'b0);
      t_merge();
      results();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      results();
   end
endmodule : tb

`default_nettype wire
